// File: design/serial_port_control_registers.sv
`timescale 1ns/1ps
// Contract
// - filter on: frames without address marking are dropped by receiver; transmitter unaffected.
// - receive-complete irq needs its enable, global flag and receive-complete flag.
// - transmit-complete irq needs its enable, global flag and transmit-complete flag.
// - buffer-empty irq needs its enable, global flag and buffer-empty flag.
// - receiver on owns receive pin; turning off flushes buffer and received ninth bit.
// - transmitter off only takes effect once shift register and buffer empty.
// - three-bit size code: 5,6,7,8 or 9 data bits; 100-110 reserved.
// - ninth received bit shown in control bit; software reads it first.
// - ninth transmit bit taken from control bit; software writes it first.
// - mode field: 00 async, 01 sync, 11 master spi, 10 reserved.
// - spi order, phase and polarity accepted in the mode-selecting write.
// - parity appended on transmit; receiver flags parity mismatch.
// - parity code: 00 off, 01 reserved, 10 even, 11 odd.
// - stop select gives one or two transmit stop bits; receiver ignores it.
// - in spi mode parity, stop select and size high bit do nothing.
// - spi order bit set sends lsb first, clear sends msb first.
// - spi phase picks leading or trailing edge for sampling.
// - sync polarity 0: output on rising, sample on falling; 1 swaps.
// - spi polarity sets idle level of the serial clock.
// - baud divisor is 12 bits: high holds top four, low holds eight.
// - writing low baud byte reloads prescaler at once.
// - receive-complete follows unread data and clears with receiver off.
// - high baud register holds bits 11:8 low, resets to zero.
module serial_port_control_registers (
  // clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_rst_b,
  // register port
  input  wire logic [7:0]                          i_addr,
  input  wire logic [7:0]                          i_wr_data,
  input  wire logic                                i_wr_stb,
  input  wire logic                                i_rd_stb,
  output logic      [7:0]                          o_rd_data,
  // cpu side
  input  wire logic                                i_global_irq_en,
  output logic                                     o_irq_rx_done,
  output logic                                     o_irq_tx_done,
  output logic                                     o_irq_tx_empty,
  // status from the shift engine
  input  wire logic                                i_rx_unread,
  input  wire logic                                i_tx_done,
  input  wire logic                                i_tx_buffer_empty,
  input  wire logic                                i_tx_shift_busy,
  input  wire logic                                i_rx_load,
  input  wire logic                                i_rx_ninth,
  input  wire logic                                i_rx_frame_done,
  input  wire logic                                i_rx_addr_mark,
  input  wire logic [8:0]                          i_tx_char,
  input  wire logic [8:0]                          i_rx_char,
  input  wire logic                                i_rx_parity_bit,
  input  wire logic                                i_rx_parity_check,
  // control to the shift engine
  output logic                                     o_rx_done_flag,
  output logic                                     o_rx_pin_own,
  output logic                                     o_tx_pin_own,
  output logic                                     o_rx_flush,
  output logic                                     o_rx_frame_accept,
  output logic                                     o_tx_ninth,
  output logic      [3:0]                          o_data_bits,
  output logic      [1:0]                          o_mode,
  output logic                                     o_parity_enable,
  output logic                                     o_tx_parity_bit,
  output logic                                     o_parity_error,
  output logic                                     o_two_stop,
  output logic                                     o_lsb_first,
  output logic                                     o_sample_leading,
  output logic                                     o_sck_idle_level,
  output logic                                     o_change_on_rising,
  output logic      [serial_ctrl_pkg::BAUD_W-1:0]  o_baud_divisor,
  output logic                                     o_baud_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0]                         irq_dir_q, irq_dir_d;
  logic [7:0]                         frame_q, frame_d;
  logic [7:0]                         baud_lo_q, baud_lo_d;
  logic [3:0]                         baud_hi_q, baud_hi_d;
  logic                               filter_q, filter_d;
  logic                               rx_ninth_q, rx_ninth_d;
  logic [7:0]                         rd_data_q, rd_data_d;
  logic                               tx_own_q, tx_own_d;
  logic                               rx_on_prev_q;
  logic                               accept_q, accept_d;
  logic                               perr_q, perr_d;
  logic [serial_ctrl_pkg::BAUD_W-1:0] pre_q, pre_d;
  logic                               tick_q, tick_d;
  logic                               baud_reload;
  serial_ctrl_pkg::op_mode_t          mode;
  logic                               is_spi;
  logic [2:0]                         size_code;
  logic [8:0]                         bit_mask;
  logic                               odd_sel;

  assign baud_reload = i_wr_stb && (i_addr == serial_ctrl_pkg::BAUD_LO_OFS);

  always_comb begin
    irq_dir_d  = irq_dir_q;
    frame_d    = frame_q;
    baud_lo_d  = baud_lo_q;
    baud_hi_d  = baud_hi_q;
    filter_d   = filter_q;
    rd_data_d  = 8'h00;
    if (i_wr_stb) begin
      unique case (i_addr)
        serial_ctrl_pkg::STATUS_OFS:  filter_d = i_wr_data[serial_ctrl_pkg::ST_FILTER_BIT];
        // the received ninth bit is read only, so it is never written here
        serial_ctrl_pkg::IRQ_DIR_OFS: irq_dir_d = {i_wr_data[7:2], 1'b0, i_wr_data[0]};
        serial_ctrl_pkg::FRAME_OFS:   frame_d = i_wr_data;
        serial_ctrl_pkg::BAUD_LO_OFS: baud_lo_d = i_wr_data;
        serial_ctrl_pkg::BAUD_HI_OFS: baud_hi_d = i_wr_data[3:0];
        default: ;
      endcase
    end
    if (i_rd_stb) begin
      unique case (i_addr)
        serial_ctrl_pkg::STATUS_OFS:  rd_data_d = {o_rx_done_flag, i_tx_done, i_tx_buffer_empty, 4'h0, filter_q};
        serial_ctrl_pkg::IRQ_DIR_OFS: rd_data_d = {irq_dir_q[7:2], rx_ninth_q, irq_dir_q[0]};
        serial_ctrl_pkg::FRAME_OFS:   rd_data_d = frame_q;
        serial_ctrl_pkg::BAUD_LO_OFS: rd_data_d = baud_lo_q;
        serial_ctrl_pkg::BAUD_HI_OFS: rd_data_d = {4'h0, baud_hi_q};
        default:                      rd_data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      irq_dir_q <= serial_ctrl_pkg::IRQ_DIR_RST;
      frame_q   <= serial_ctrl_pkg::FRAME_RST;
      baud_lo_q <= serial_ctrl_pkg::BAUD_LO_RST;
      baud_hi_q <= serial_ctrl_pkg::BAUD_HI_RST;
      filter_q  <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      irq_dir_q <= irq_dir_d;
      frame_q   <= frame_d;
      baud_lo_q <= baud_lo_d;
      baud_hi_q <= baud_hi_d;
      filter_q  <= filter_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign o_rd_data = rd_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt gating

  assign o_rx_done_flag = irq_dir_q[serial_ctrl_pkg::RX_ON_BIT] && i_rx_unread;
  assign o_irq_rx_done  = irq_dir_q[serial_ctrl_pkg::RX_DONE_IE_BIT] && i_global_irq_en && o_rx_done_flag;
  assign o_irq_tx_done  = irq_dir_q[serial_ctrl_pkg::TX_DONE_IE_BIT] && i_global_irq_en && i_tx_done;
  assign o_irq_tx_empty = irq_dir_q[serial_ctrl_pkg::TX_EMPTY_IE_BIT] && i_global_irq_en
                          && i_tx_buffer_empty;

  ////////////////////////////////////////////////////////////////////////////
  // direction control and pin ownership

  always_comb begin
    // hold the pin until nothing is left to send, so a late clear cannot cut a frame
    tx_own_d   = irq_dir_q[serial_ctrl_pkg::TX_ON_BIT]
                 || (tx_own_q && (i_tx_shift_busy || !i_tx_buffer_empty));
    rx_ninth_d = i_rx_load ? i_rx_ninth : rx_ninth_q;
    if (o_rx_flush) begin
      rx_ninth_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      tx_own_q     <= 1'b0;
      rx_ninth_q   <= 1'b0;
      rx_on_prev_q <= 1'b0;
    end else begin
      tx_own_q     <= tx_own_d;
      rx_ninth_q   <= rx_ninth_d;
      rx_on_prev_q <= irq_dir_q[serial_ctrl_pkg::RX_ON_BIT];
    end
  end

  assign o_tx_pin_own = tx_own_q;
  assign o_rx_pin_own = irq_dir_q[serial_ctrl_pkg::RX_ON_BIT];
  assign o_rx_flush   = rx_on_prev_q && !irq_dir_q[serial_ctrl_pkg::RX_ON_BIT];
  assign o_tx_ninth   = irq_dir_q[serial_ctrl_pkg::TX_NINTH_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // frame format decode

  assign mode   = serial_ctrl_pkg::op_mode_t'(frame_q[serial_ctrl_pkg::MODE_LSB +: 2]);
  assign o_mode = frame_q[serial_ctrl_pkg::MODE_LSB +: 2];
  assign is_spi = (mode == serial_ctrl_pkg::MODE_SPI);

  assign size_code = {irq_dir_q[serial_ctrl_pkg::SIZE_HI_BIT], frame_q[serial_ctrl_pkg::SIZE_LSB +: 2]};

  always_comb begin
    // reserved size codes fall back to eight bits; spi frames are always eight
    unique case (size_code)
      3'h0:    o_data_bits = 4'h5;
      3'h1:    o_data_bits = 4'h6;
      3'h2:    o_data_bits = 4'h7;
      3'h7:    o_data_bits = 4'h9;
      default: o_data_bits = 4'h8;
    endcase
    if (is_spi) begin
      o_data_bits = 4'h8;
    end
  end

  // parity 01 is reserved and treated as off
  assign o_parity_enable = !is_spi && (frame_q[serial_ctrl_pkg::PARITY_LSB +: 2] == serial_ctrl_pkg::PAR_EVEN
                           || frame_q[serial_ctrl_pkg::PARITY_LSB +: 2] == serial_ctrl_pkg::PAR_ODD);
  assign odd_sel         = frame_q[serial_ctrl_pkg::PARITY_LSB +: 2] == serial_ctrl_pkg::PAR_ODD;
  assign o_two_stop      = !is_spi && frame_q[serial_ctrl_pkg::STOP_BIT];

  assign o_lsb_first        = is_spi && frame_q[serial_ctrl_pkg::ORDER_BIT];
  assign o_sample_leading   = is_spi && !frame_q[serial_ctrl_pkg::PHASE_BIT];
  assign o_sck_idle_level   = frame_q[serial_ctrl_pkg::POLARITY_BIT];
  assign o_change_on_rising = !frame_q[serial_ctrl_pkg::POLARITY_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // parity and address filter

  for (genvar i = 0; i < serial_ctrl_pkg::MAX_BITS; i++) begin : g_mask
    assign bit_mask[i] = (4'(i) < o_data_bits);
  end

  assign o_tx_parity_bit = (^(i_tx_char & bit_mask)) ^ odd_sel;

  always_comb begin
    perr_d   = o_parity_enable && i_rx_parity_check
               && (((^(i_rx_char & bit_mask)) ^ odd_sel) != i_rx_parity_bit);
    // the filter acts on the receiver only
    accept_d = i_rx_frame_done && (!filter_q || i_rx_addr_mark);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      perr_q   <= 1'b0;
      accept_q <= 1'b0;
    end else begin
      perr_q   <= perr_d;
      accept_q <= accept_d;
    end
  end

  assign o_parity_error    = perr_q;
  assign o_rx_frame_accept = accept_q;

  ////////////////////////////////////////////////////////////////////////////
  // baud prescaler

  assign o_baud_divisor = {baud_hi_q, baud_lo_q};

  always_comb begin
    tick_d = 1'b0;
    if (baud_reload) begin
      // new divisor takes over at once; a frame in flight is corrupted
      pre_d = {baud_hi_q, i_wr_data};
    end else if (pre_q == '0) begin
      pre_d  = o_baud_divisor;
      tick_d = 1'b1;
    end else begin
      pre_d = pre_q - 12'h001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
    end
  end

  assign o_baud_tick = tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_rx_irq;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_irq_rx_done |-> irq_dir_q[7] && i_global_irq_en && i_rx_unread && irq_dir_q[4];
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq without its causes");

  property p_tx_irq;
    @(posedge i_clk) disable iff (!i_rst_b)
    (irq_dir_q[6] && i_global_irq_en && i_tx_done) |-> o_irq_tx_done;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx done irq missing");

  property p_empty_irq;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_irq_tx_empty |-> (irq_dir_q[5] && i_global_irq_en && i_tx_buffer_empty);
  endproperty
  a_empty_irq: assert property (p_empty_irq) else $error("empty irq without its causes");

  property p_flush;
    @(posedge i_clk) disable iff (!i_rst_b)
    $fell(irq_dir_q[4]) |-> o_rx_flush && !o_rx_done_flag ##1 !o_rx_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("receiver off did not flush");

  property p_tx_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
    (o_tx_pin_own && (i_tx_shift_busy || !i_tx_buffer_empty)) |=> o_tx_pin_own;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx pin released while busy");

  property p_reload;
    @(posedge i_clk) disable iff (!i_rst_b)
    baud_reload |=> pre_q == {baud_hi_q, $past(i_wr_data)} && o_baud_divisor == pre_q;
  endproperty
  a_reload: assert property (p_reload) else $error("prescaler not reloaded");

  property p_filter;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_rx_frame_done && filter_q && !i_rx_addr_mark) |=> !o_rx_frame_accept;
  endproperty
  a_filter: assert property (p_filter) else $error("unmarked frame accepted");

  property p_spi_reserved;
    @(posedge i_clk) disable iff (!i_rst_b)
    is_spi |-> !o_parity_enable && !o_two_stop && o_data_bits == 4'h8;
  endproperty
  a_spi_reserved: assert property (p_spi_reserved) else $error("spi mode used reserved fields");

  property p_ninth;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_rx_load && !o_rx_flush) |=> rx_ninth_q == $past(i_rx_ninth);
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit not captured");

  property p_size9;
    @(posedge i_clk) disable iff (!i_rst_b)
    (!is_spi && size_code == 3'h7) |-> o_data_bits == 4'h9;
  endproperty
  a_size9: assert property (p_size9) else $error("nine bit size wrong");

endmodule : serial_port_control_registers

// File: design/serial_ctrl_pkg.sv
package serial_ctrl_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] STATUS_OFS   = 8'hc0;
  localparam logic [7:0] IRQ_DIR_OFS  = 8'hc1;
  localparam logic [7:0] FRAME_OFS    = 8'hc2;
  localparam logic [7:0] BAUD_LO_OFS  = 8'hc4;
  localparam logic [7:0] BAUD_HI_OFS  = 8'hc5;

  // reset values
  localparam logic [7:0] IRQ_DIR_RST  = 8'h00;
  localparam logic [7:0] FRAME_RST    = 8'h06;
  localparam logic [7:0] BAUD_LO_RST  = 8'h00;
  localparam logic [3:0] BAUD_HI_RST  = 4'h0;

  // irq_enable_and_direction_control fields
  localparam int RX_DONE_IE_BIT  = 7;
  localparam int TX_DONE_IE_BIT  = 6;
  localparam int TX_EMPTY_IE_BIT = 5;
  localparam int RX_ON_BIT       = 4;
  localparam int TX_ON_BIT       = 3;
  localparam int SIZE_HI_BIT     = 2;
  localparam int RX_NINTH_BIT    = 1;
  localparam int TX_NINTH_BIT    = 0;

  // frame_format_control fields
  localparam int MODE_LSB      = 6;
  localparam int PARITY_LSB    = 4;
  localparam int STOP_BIT      = 3;
  localparam int SIZE_LSB      = 1;
  localparam int ORDER_BIT     = 2;
  localparam int PHASE_BIT     = 1;
  localparam int POLARITY_BIT  = 0;

  // status word fields
  localparam int ST_RX_DONE_BIT  = 7;
  localparam int ST_TX_DONE_BIT  = 6;
  localparam int ST_TX_EMPTY_BIT = 5;
  localparam int ST_FILTER_BIT   = 0;

  localparam int BAUD_W      = 12;
  localparam int MAX_BITS    = 9;

  typedef enum logic [1:0] {
    MODE_ASYNC,
    MODE_SYNC,
    MODE_RESERVED,
    MODE_SPI
  } op_mode_t;

  localparam logic [1:0] PAR_OFF  = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD  = 2'h3;

endpackage : serial_ctrl_pkg

// File: bench/serial_engine_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module serial_engine_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // requests from the bench
  input  wire logic i_req_frame,
  input  wire logic i_req_mark,
  input  wire logic i_req_ninth,
  input  wire logic i_req_send,
  // controls from the block
  input  wire logic i_accept,
  input  wire logic i_flush,
  // status into the block
  output logic      o_rx_unread,
  output logic      o_rx_load,
  output logic      o_rx_ninth,
  output logic      o_frame_done,
  output logic      o_addr_mark,
  output logic      o_tx_done,
  output logic      o_buf_empty,
  output logic      o_busy
);
  logic [2:0] busy_q;
  logic       ninth_q;
  assign o_busy = (busy_q != 3'h0);
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      busy_q       <= 3'h0;
      ninth_q      <= 1'b0;
      o_rx_unread  <= 1'b0;
      o_rx_load    <= 1'b0;
      o_rx_ninth   <= 1'b0;
      o_frame_done <= 1'b0;
      o_addr_mark  <= 1'b0;
      o_tx_done    <= 1'b0;
      o_buf_empty  <= 1'b1;
    end else begin
      o_frame_done <= i_req_frame;
      // qualifiers flip off-pulse so nobody leans on a stale value
      o_addr_mark  <= i_req_frame ? i_req_mark : ~o_addr_mark;
      if (i_req_frame) begin
        ninth_q <= i_req_ninth;
      end
      o_rx_load  <= i_accept;
      o_rx_ninth <= i_accept ? ninth_q : ~o_rx_ninth;
      if (i_accept) begin
        o_rx_unread <= 1'b1;
      end
      if (i_flush) begin
        o_rx_unread <= 1'b0;
      end
      o_buf_empty <= ~i_req_send;
      if (i_req_send) begin
        busy_q    <= 3'h4;
        o_tx_done <= 1'b0;
      end else if (busy_q == 3'h1) begin
        busy_q    <= 3'h0;
        o_tx_done <= 1'b1;
      end else if (o_busy) begin
        busy_q <= busy_q - 3'h1;
      end
    end
  end
endmodule : serial_engine_model

// File: bench/serial_port_control_registers_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); end end
module serial_port_control_registers_bench;
  logic       i_clk = 1'b0, i_rst_b = 1'b0, i_wr_stb = 1'b0, i_rd_stb = 1'b0, i_global_irq_en = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, o_rd_data;
  logic [8:0] i_tx_char = 9'h0b3, i_rx_char = 9'h0b3;
  logic       i_rx_parity_bit = 1'b0, i_rx_parity_check = 1'b0;
  logic       req_frame = 1'b0, req_mark = 1'b0, req_ninth = 1'b0, req_send = 1'b0;
  logic       i_rx_unread, i_tx_done, i_tx_buffer_empty, i_tx_shift_busy, i_rx_load, i_rx_ninth;
  logic       i_rx_frame_done, i_rx_addr_mark, o_irq_rx_done, o_irq_tx_done, o_irq_tx_empty;
  logic       o_rx_done_flag, o_rx_pin_own, o_tx_pin_own, o_rx_flush, o_rx_frame_accept, o_tx_ninth;
  logic       o_parity_enable, o_tx_parity_bit, o_parity_error, o_two_stop, o_lsb_first;
  logic       o_sample_leading, o_sck_idle_level, o_change_on_rising, o_baud_tick;
  logic [3:0] o_data_bits;
  logic [1:0] o_mode;
  logic [11:0] o_baud_divisor;
  logic [3:0] sz [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h8, 4'h8, 4'h8, 4'h9};
  int         fails = 0, n_tests = 0, n_acc, n_flush, n_tick, n;
  logic [3:0] k;

  serial_port_control_registers dut_u (.i_clk, .i_rst_b, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb,
    .o_rd_data, .i_global_irq_en, .o_irq_rx_done, .o_irq_tx_done, .o_irq_tx_empty, .i_rx_unread,
    .i_tx_done, .i_tx_buffer_empty, .i_tx_shift_busy, .i_rx_load, .i_rx_ninth, .i_rx_frame_done,
    .i_rx_addr_mark, .i_tx_char, .i_rx_char, .i_rx_parity_bit, .i_rx_parity_check, .o_rx_done_flag,
    .o_rx_pin_own, .o_tx_pin_own, .o_rx_flush, .o_rx_frame_accept, .o_tx_ninth, .o_data_bits, .o_mode,
    .o_parity_enable, .o_tx_parity_bit, .o_parity_error, .o_two_stop, .o_lsb_first, .o_sample_leading,
    .o_sck_idle_level, .o_change_on_rising, .o_baud_divisor, .o_baud_tick);
  serial_engine_model model_u (.i_clk, .i_rst_b, .i_req_frame(req_frame), .i_req_mark(req_mark),
    .i_req_ninth(req_ninth), .i_req_send(req_send), .i_accept(o_rx_frame_accept), .i_flush(o_rx_flush),
    .o_rx_unread(i_rx_unread), .o_rx_load(i_rx_load), .o_rx_ninth(i_rx_ninth),
    .o_frame_done(i_rx_frame_done), .o_addr_mark(i_rx_addr_mark), .o_tx_done(i_tx_done),
    .o_buf_empty(i_tx_buffer_empty), .o_busy(i_tx_shift_busy));

  always #5 i_clk = ~i_clk;
////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr_stb  <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd_stb <= 1'b1;
    i_addr   <= a;
    @(posedge i_clk);
    i_rd_stb <= 1'b0;
    #1;
    `CHK(o_rd_data, exp)
  endtask : rd
  // samples the current cycle first, so a pulse right after a write is seen
  task automatic run(input int cycles);
    n_acc   = 0;
    n_flush = 0;
    n_tick  = 0;
    repeat (cycles) begin
      n_acc   += (o_rx_frame_accept === 1'b1);
      n_flush += (o_rx_flush === 1'b1);
      n_tick  += (o_baud_tick === 1'b1);
      @(posedge i_clk);
      #1;
    end
  endtask : run
  task automatic frame(input logic mark, input logic ninth, input int exp);
    @(posedge i_clk);
    req_frame <= 1'b1;
    req_mark  <= mark;
    req_ninth <= ninth;
    @(posedge i_clk);
    req_frame <= 1'b0;
    #1;
    run(4);
    `CHK(n_acc, exp)
  endtask : frame
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    print_verdict();
  end
////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(8'hc1, 8'h00);
    rd(8'hc2, 8'h06);
    rd(8'hc4, 8'h00);
    rd(8'hc5, 8'h00);
    rd(8'hc0, 8'h20);
    wr(8'hc3, 8'hff);
    rd(8'hc3, 8'h00);
    wr(8'hc1, 8'h02);
    rd(8'hc1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      k = 4'(i);
      wr(8'hc1, {5'h0, k[2], 2'h0});
      wr(8'hc2, {5'h0, k[1:0], 1'b0});
      `CHK(o_data_bits, sz[i])
      wr(8'hc2, {k[1:0], 6'h06});
      `CHK(o_mode, k[1:0])
      wr(8'hc2, {2'h0, k[1:0], 4'h6});
      `CHK(o_parity_enable, k[1])
      if (k[1]) `CHK(o_tx_parity_bit, ~k[0])
      @(posedge i_clk);
      i_rx_parity_check <= 1'b1;
      @(posedge i_clk);
      i_rx_parity_check <= 1'b0;
      #1;
      `CHK(o_parity_error, (k[1:0] == 2'h2))
      wr(8'hc2, 8'hc0 | {5'h0, k[2:0]});
      `CHK(o_lsb_first, k[2])
      `CHK(o_sample_leading, ~k[1])
      `CHK(o_sck_idle_level, k[0])
    end
    wr(8'hc1, 8'h04);
    wr(8'hc2, 8'hfe);
    `CHK(o_data_bits, 4'h8)
    `CHK(o_parity_enable, 1'b0)
    wr(8'hc2, 8'h47);
    `CHK(o_change_on_rising, 1'b0)
    wr(8'hc2, 8'h0e);
    `CHK(o_change_on_rising, 1'b1)
    `CHK(o_two_stop, 1'b1)
    wr(8'hc2, 8'h06);
    `CHK(o_two_stop, 1'b0)
    wr(8'hc1, 8'h01);
    `CHK(o_tx_ninth, 1'b1)
    // transmitter release waits for the engine to drain
    wr(8'hc1, 8'h08);
    @(posedge i_clk);
    #1;
    `CHK(o_tx_pin_own, 1'b1)
    @(posedge i_clk);
    req_send <= 1'b1;
    @(posedge i_clk);
    req_send <= 1'b0;
    wr(8'hc1, 8'h00);
    `CHK(o_tx_pin_own, 1'b1)
    n = 0;
    while (i_tx_shift_busy && n < 20) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    repeat (2) @(posedge i_clk);
    #1;
    `CHK(o_tx_pin_own, 1'b0)
    wr(8'hc1, 8'h10);
    `CHK(o_rx_pin_own, 1'b1)
    wr(8'hc0, 8'h01);
    frame(1'b0, 1'b0, 0);
    frame(1'b1, 1'b0, 1);
    wr(8'hc0, 8'h00);
    frame(1'b0, 1'b1, 1);
    `CHK(o_rx_done_flag, 1'b1)
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      @(posedge i_clk);
      i_global_irq_en <= k[3];
      wr(8'hc1, {k[2:0], 5'h10});
      `CHK(o_irq_rx_done, k[2] & k[3])
      `CHK(o_irq_tx_done, k[1] & k[3])
      `CHK(o_irq_tx_empty, k[0] & k[3])
    end
    rd(8'hc1, 8'hf2);
    rd(8'hc0, 8'he0);
    wr(8'hc1, 8'h00);
    run(3);
    `CHK(n_flush, 1)
    `CHK(o_rx_done_flag, 1'b0)
    `CHK(o_rx_pin_own, 1'b0)
    rd(8'hc1, 8'h00);
    wr(8'hc5, 8'h0a);
    wr(8'hc4, 8'h5c);
    `CHK(o_baud_divisor, 12'ha5c)
    rd(8'hc5, 8'h0a);
    rd(8'hc4, 8'h5c);
    wr(8'hc5, 8'h00);
    wr(8'hc4, 8'h03);
    run(40);
    // divisor 3 gives a period of 4; first tick 4 cycles after the reload, so 9 in the window
    `CHK(n_tick, 9)
    print_verdict();
  end
endmodule : serial_port_control_registers_bench
